/* core/uao_defs.svh */
// Offsets, field positions, reset values and timing counts of the async serial channel
`ifndef UAO_DEFS_SVH
`define UAO_DEFS_SVH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define UAO_OFF_MODE 5'h00
`define UAO_OFF_CTRL 5'h04
`define UAO_OFF_BRG 5'h08
`define UAO_OFF_TXBUF 5'h0C
`define UAO_OFF_RXBUF 5'h10
`define UAO_OFF_STAT 5'h14
`define UAO_OFF_IRQ 5'h18
`define UAO_OFF_MASK 5'h1C
// ----------------------------------------
// Mode register fields
// ----------------------------------------
`define UAO_MODE_LEN0 0
`define UAO_MODE_LEN1 1
`define UAO_MODE_EXT 3
`define UAO_MODE_STOP2 4
`define UAO_MODE_PEVEN 5
`define UAO_MODE_PEN 6
`define UAO_MODE_SLEEP 7
// ----------------------------------------
// Control register fields
// ----------------------------------------
`define UAO_CTRL_TXEN 0
`define UAO_CTRL_ASYNC 1
`define UAO_CTRL_RXEN 2
`define UAO_CTRL_FCFUNC 3
`define UAO_CTRL_FCDIS 4
`define UAO_CTRL_REV 5
`define UAO_CTRL_INV 6
`define UAO_CTRL_OD 7
// ----------------------------------------
// Interrupt status and mask bits
// ----------------------------------------
`define UAO_IRQ_TX 0
`define UAO_IRQ_RX 1
`define UAO_IRQ_ERR 2
`define UAO_IRQ_COLL 3
// ----------------------------------------
// Reset values and timing counts
// ----------------------------------------
`define UAO_MODE_RST 8'h01
`define UAO_CTRL_RST 8'h10
`define UAO_BRG_RST 8'h00
`define UAO_OS_LAST 4'hF
`define UAO_OS_MID 4'h8
`define UAO_OS_START 4'h7
`endif

/* core/uao_pkg.sv */
// State types of the async serial channel
package uao_pkg;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_DATA = 3'b010,
    TX_PAR = 3'b011,
    TX_STOP = 3'b100
  } uao_tx_st_t;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_PAR = 3'b011,
    RX_STOP = 3'b100
  } uao_rx_st_t;
endpackage : uao_pkg

/* core/uao_baud_gen.sv */
// Oversampling tick generator: internal clock or transfer clock pin, divided by n+1
`timescale 1ns/1ps
module uao_baud_gen (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_ext_sel,
  input wire logic i_ext_pin,
  input wire logic [7:0] i_div,
  output logic o_tick
);
  logic pin_q;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic tick_q;
  // ----------------------------------------
  // Base event and divider
  // ----------------------------------------
  // External clock counts its rising edges, the internal one counts every cycle
  wire base_ev = i_ext_sel ? (i_ext_pin & ~pin_q) : 1'b1;
  wire wrap = base_ev & (cnt_q >= i_div);
  assign cnt_d = wrap ? 8'h00 : (base_ev ? cnt_q + 8'h01 : cnt_q);
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pin_q <= 1'b0;
      cnt_q <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      pin_q <= i_ext_pin;
      cnt_q <= cnt_d;
      tick_q <= wrap;
    end
  end
  assign o_tick = tick_q;
endmodule : uao_baud_gen

/* core/uao_core.sv */
// One async serial channel: sleep on channels other than two; data inversion, line reversal and collision options on channel two only
`timescale 1ns/1ps
`include "uao_defs.svh"
module uao_core import uao_pkg::*; #(
  parameter int CHANNEL = 2
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [4:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_serial_in_pin,
  output logic o_serial_out_pin,
  output logic o_serial_out_oe,
  input wire logic i_transfer_clock_pin,
  output logic o_transfer_clock_is_port,
  input wire logic i_flow_control_pin,
  output logic o_flow_control_pin,
  output logic o_flow_control_oe,
  output logic o_flow_control_is_port,
  output logic o_serial_in_is_port,
  output logic o_irq
);
  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  logic [1:0] rst_sync_q;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) rst_sync_q <= 2'b00;
    else rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  wire rst_n = rst_sync_q[1];

  logic [7:0] mode_q, ctrl_q, brg_q;
  logic [8:0] txbuf_q, rxbuf_q, tx_sh_q, rx_sh_q;
  logic tx_full_q, rx_full_q, ovr_q, fer_q, per_q, ack_q, irq_q;
  logic [3:0] irq_st_q, irq_mask_q, tx_cnt_q, rx_cnt_q, tx_bit_q, rx_bit_q;
  logic tx_par_q, rx_par_q, rx_fer_q, rx_per_q, out_q, oe_q;
  logic clk_port_q, fc_pin_q, fc_oe_q, fc_port_q, in_port_q;
  logic [31:0] rd_d;
  uao_tx_st_t tx_st_q;
  uao_rx_st_t rx_st_q;
  wire tick;

  // ----------------------------------------
  // Option decode
  // ----------------------------------------
  // Options absent on a channel are forced off so software cannot reach them
  wire ch2 = (CHANNEL == 2);
  wire sleep_en = mode_q[`UAO_MODE_SLEEP] & ~ch2;
  wire inv_en = ctrl_q[`UAO_CTRL_INV] & ch2;
  wire rev_en = ctrl_q[`UAO_CTRL_REV] & ch2;
  wire ext_clk = mode_q[`UAO_MODE_EXT] & ~ch2;
  wire async_on = ctrl_q[`UAO_CTRL_ASYNC];
  wire rx_en = ctrl_q[`UAO_CTRL_RXEN];
  wire fc_dis = ctrl_q[`UAO_CTRL_FCDIS];
  wire fc_func = ctrl_q[`UAO_CTRL_FCFUNC];
  wire od = ctrl_q[`UAO_CTRL_OD];
  wire [3:0] nbits = mode_q[`UAO_MODE_LEN1] ? 4'h9 : (mode_q[`UAO_MODE_LEN0] ? 4'h8 : 4'h7);
  wire [8:0] char_mask = mode_q[`UAO_MODE_LEN1] ? 9'h1FF : (mode_q[`UAO_MODE_LEN0] ? 9'h0FF : 9'h07F);
  wire [8:0] inv_mask = inv_en ? char_mask : 9'h000;

  uao_baud_gen u_baud (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(rst_n),
    .i_ext_sel(ext_clk),
    .i_ext_pin(i_transfer_clock_pin),
    .i_div(brg_q),
    .o_tick(tick)
  );

  // ----------------------------------------
  // Wishbone decode
  // ----------------------------------------
  // Writes and read side effects land on the acknowledging edge only
  wire wb_req = i_wb_cyc & i_wb_stb;
  wire [4:0] wb_off = {i_wb_adr[4:2], 2'b00};
  wire wr = wb_req & i_wb_we & ack_q & i_wb_sel[0];
  wire rd_take = wb_req & ~i_wb_we & ack_q;
  wire wr_mode = wr & (wb_off == `UAO_OFF_MODE);
  wire wr_ctrl = wr & (wb_off == `UAO_OFF_CTRL);
  wire wr_brg = wr & (wb_off == `UAO_OFF_BRG);
  wire wr_tx = wr & (wb_off == `UAO_OFF_TXBUF);
  wire wr_irq = wr & (wb_off == `UAO_OFF_IRQ);
  wire wr_mask = wr & (wb_off == `UAO_OFF_MASK);
  wire rd_rx = rd_take & (wb_off == `UAO_OFF_RXBUF);
  wire [8:0] tx_wdat = {i_wb_sel[1] & i_wb_dat[8], i_wb_dat[7:0]};
  wire err_sum = ovr_q | fer_q | per_q;
  wire [7:0] stat = {rx_st_q != RX_IDLE, err_sum, per_q, fer_q, ovr_q, rx_full_q, tx_st_q != TX_IDLE, tx_full_q};

  // Read mux; unmapped offsets answer with zero
  always_comb begin
    rd_d = 32'h0000_0000;
    unique case (wb_off)
      `UAO_OFF_MODE: rd_d[7:0] = mode_q;
      `UAO_OFF_CTRL: rd_d[7:0] = ctrl_q;
      `UAO_OFF_BRG: rd_d[7:0] = brg_q;
      `UAO_OFF_TXBUF: rd_d[8:0] = (txbuf_q ^ inv_mask) & char_mask;
      `UAO_OFF_RXBUF: rd_d[8:0] = (rxbuf_q ^ inv_mask) & char_mask;
      `UAO_OFF_STAT: rd_d[7:0] = stat;
      `UAO_OFF_IRQ: rd_d[3:0] = irq_st_q;
      `UAO_OFF_MASK: rd_d[3:0] = irq_mask_q;
      default: rd_d = 32'h0000_0000;
    endcase
  end

  // Registered answer, one cycle after the request is seen
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_q <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      ack_q <= wb_req & ~ack_q;
      if (wb_req & ~ack_q) o_wb_dat <= rd_d;
    end
  end
  assign o_wb_ack = ack_q;

  // Configuration registers
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= `UAO_MODE_RST;
      ctrl_q <= `UAO_CTRL_RST;
      brg_q <= `UAO_BRG_RST;
      irq_mask_q <= 4'h0;
      txbuf_q <= 9'h000;
    end else begin
      if (wr_mode) mode_q <= i_wb_dat[7:0];
      if (wr_ctrl) ctrl_q <= i_wb_dat[7:0];
      if (wr_brg) brg_q <= i_wb_dat[7:0];
      if (wr_mask) irq_mask_q <= i_wb_dat[3:0];
      if (wr_tx) txbuf_q <= (tx_wdat ^ inv_mask) & char_mask;
    end
  end

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  wire cts_ok = fc_dis | fc_func | ~i_flow_control_pin;
  wire tx_go = (tx_st_q == TX_IDLE) & async_on & ctrl_q[`UAO_CTRL_TXEN] & tx_full_q & cts_ok;
  wire tx_bit_end = tick & (tx_cnt_q == `UAO_OS_LAST);
  wire tx_done = tx_bit_end & (tx_st_q == TX_STOP) & (tx_bit_q[0] == mode_q[`UAO_MODE_STOP2]);
  // Framing bits come from the state, never from the buffer, so inversion cannot touch them
  wire tx_lvl = (tx_st_q == TX_START) ? 1'b0 : (tx_st_q == TX_DATA) ? tx_sh_q[0] :
                (tx_st_q == TX_PAR) ? tx_par_q : 1'b1;
  wire coll_ev = ch2 & tick & (tx_cnt_q == `UAO_OS_MID) & (tx_st_q != TX_IDLE) & (out_q != i_serial_in_pin);

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_st_q <= TX_IDLE;
      tx_cnt_q <= 4'h0;
      tx_bit_q <= 4'h0;
      tx_sh_q <= 9'h000;
      tx_par_q <= 1'b0;
    end else begin
      if (tick) tx_cnt_q <= (tx_st_q == TX_IDLE) ? 4'h0 : tx_cnt_q + 4'h1;
      unique case (tx_st_q)
        TX_IDLE: if (tx_go) begin
          tx_st_q <= TX_START;
          tx_sh_q <= txbuf_q;
          tx_par_q <= ~mode_q[`UAO_MODE_PEVEN];
          tx_bit_q <= 4'h0;
        end
        TX_START: if (tx_bit_end) tx_st_q <= TX_DATA;
        TX_DATA: if (tx_bit_end) begin
          tx_sh_q <= {1'b0, tx_sh_q[8:1]};
          tx_par_q <= tx_par_q ^ tx_sh_q[0];
          tx_bit_q <= tx_bit_q + 4'h1;
          if (tx_bit_q == nbits - 4'h1) begin
            tx_st_q <= mode_q[`UAO_MODE_PEN] ? TX_PAR : TX_STOP;
            tx_bit_q <= 4'h0;
          end
        end
        TX_PAR: if (tx_bit_end) tx_st_q <= TX_STOP;
        TX_STOP: if (tx_bit_end) begin
          tx_bit_q <= tx_bit_q + 4'h1;
          if (tx_done) tx_st_q <= TX_IDLE;
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  wire rx_lvl = i_serial_in_pin ^ rev_en;
  wire rx_bit_end = tick & (rx_cnt_q == `UAO_OS_LAST);
  wire rx_done = rx_bit_end & (rx_st_q == RX_STOP) & (rx_bit_q[0] == mode_q[`UAO_MODE_STOP2]);
  wire rx_msb = rx_sh_q[nbits - 4'h1];
  wire rx_fer_now = rx_fer_q | ~rx_lvl;
  wire rx_accept = rx_done & (~sleep_en | rx_msb);

  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_st_q <= RX_IDLE;
      rx_cnt_q <= 4'h0;
      rx_bit_q <= 4'h0;
      rx_sh_q <= 9'h000;
      rx_par_q <= 1'b0;
      rx_fer_q <= 1'b0;
      rx_per_q <= 1'b0;
    end else begin
      if (tick) rx_cnt_q <= (rx_st_q == RX_IDLE) ? 4'h0 : rx_cnt_q + 4'h1;
      unique case (rx_st_q)
        RX_IDLE: if (async_on & rx_en & ~rx_lvl) begin
          rx_st_q <= RX_START;
          rx_sh_q <= 9'h000;
          rx_bit_q <= 4'h0;
          rx_par_q <= ~mode_q[`UAO_MODE_PEVEN];
          rx_fer_q <= 1'b0;
          rx_per_q <= 1'b0;
        end
        // Half a bit in, a high line means a glitch, not a start bit
        RX_START: if (tick & (rx_cnt_q == `UAO_OS_START)) begin
          rx_st_q <= rx_lvl ? RX_IDLE : RX_DATA;
          rx_cnt_q <= 4'h0;
        end
        RX_DATA: if (rx_bit_end) begin
          rx_sh_q[rx_bit_q] <= rx_lvl;
          rx_par_q <= rx_par_q ^ rx_lvl;
          rx_bit_q <= rx_bit_q + 4'h1;
          if (rx_bit_q == nbits - 4'h1) begin
            rx_st_q <= mode_q[`UAO_MODE_PEN] ? RX_PAR : RX_STOP;
            rx_bit_q <= 4'h0;
          end
        end
        RX_PAR: if (rx_bit_end) begin
          rx_per_q <= (rx_lvl != rx_par_q);
          rx_st_q <= RX_STOP;
        end
        RX_STOP: if (rx_bit_end) begin
          rx_fer_q <= rx_fer_now;
          rx_bit_q <= rx_bit_q + 4'h1;
          if (rx_done) rx_st_q <= RX_IDLE;
        end
        default: rx_st_q <= RX_IDLE;
      endcase
    end
  end

  // Buffers, error flags; a new frame wins over a clearing read
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_full_q <= 1'b0;
      rx_full_q <= 1'b0;
      rxbuf_q <= 9'h000;
      ovr_q <= 1'b0;
      fer_q <= 1'b0;
      per_q <= 1'b0;
    end else begin
      tx_full_q <= (tx_full_q & ~tx_go) | wr_tx;
      rx_full_q <= (rx_full_q & ~rd_rx) | rx_accept;
      if (rx_accept) begin
        rxbuf_q <= rx_sh_q;
        ovr_q <= rx_full_q & ~rd_rx;
        fer_q <= rx_fer_now;
        per_q <= rx_per_q;
      end
    end
  end

  // ----------------------------------------
  // Interrupts and pins
  // ----------------------------------------
  // Overrun keeps the receive event quiet; the error event reports it instead
  wire err_ev = rx_accept & (rx_fer_now | rx_per_q | (rx_full_q & ~rd_rx));
  wire [3:0] ev = {coll_ev, err_ev, rx_accept & ~(rx_full_q & ~rd_rx), tx_done};
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_st_q <= 4'h0;
      irq_q <= 1'b0;
    end else begin
      irq_st_q <= (irq_st_q & ~(wr_irq ? i_wb_dat[3:0] : 4'h0)) | ev;
      irq_q <= |(irq_st_q & irq_mask_q);
    end
  end
  assign o_irq = irq_q;

  // Pin drivers; open drain only drives the low level, so idle high floats
  always_ff @(posedge i_ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= 1'b1;
      oe_q <= 1'b0;
      clk_port_q <= 1'b1;
      fc_pin_q <= 1'b1;
      fc_oe_q <= 1'b0;
      fc_port_q <= 1'b1;
      in_port_q <= 1'b1;
    end else begin
      out_q <= async_on ? (tx_lvl ^ rev_en) : 1'b1;
      oe_q <= async_on & (~od | ~(tx_lvl ^ rev_en));
      clk_port_q <= ~ext_clk;
      fc_pin_q <= ~(rx_en & ~rx_full_q);
      fc_oe_q <= ~fc_dis & fc_func;
      fc_port_q <= fc_dis;
      in_port_q <= ~rx_en;
    end
  end
  assign o_serial_out_pin = out_q;
  assign o_serial_out_oe = oe_q;
  assign o_transfer_clock_is_port = clk_port_q;
  assign o_flow_control_pin = fc_pin_q;
  assign o_flow_control_oe = fc_oe_q;
  assign o_flow_control_is_port = fc_port_q;
  assign o_serial_in_is_port = in_port_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!rst_n);
  a_option_gate: assert property (ch2 |-> !sleep_en) else $error("sleep active on channel two");
  a_sleep_drop: assert property (rx_done && sleep_en && !rx_msb |=> $stable(rxbuf_q) && !irq_st_q[`UAO_IRQ_ERR] || $past(irq_st_q[`UAO_IRQ_ERR])) else $error("ignored frame changed state");
  a_sleep_keep: assert property (rx_done && sleep_en && rx_msb |=> rxbuf_q == $past(rx_sh_q)) else $error("sleep frame lost");
  a_tx_invert: assert property (wr_tx |=> txbuf_q == (($past(tx_wdat) ^ $past(inv_mask)) & $past(char_mask))) else $error("tx data logic wrong");
  a_start_level: assert property (tx_st_q == TX_START && async_on |=> o_serial_out_pin == $past(rev_en)) else $error("start bit level wrong");
  a_idle_high: assert property (async_on && tx_st_q == TX_IDLE && !rev_en && !od |=> o_serial_out_pin && o_serial_out_oe) else $error("idle out not high");
  a_od_float: assert property (async_on && tx_st_q == TX_IDLE && !rev_en && od |=> !o_serial_out_oe) else $error("open drain idle driven");
  a_coll_flag: assert property (coll_ev |=> irq_st_q[`UAO_IRQ_COLL] ##1 (irq_st_q[`UAO_IRQ_COLL] || $past(wr_irq))) else $error("collision not flagged");
  a_clk_port: assert property (!mode_q[`UAO_MODE_EXT] |=> o_transfer_clock_is_port) else $error("clock pin not freed");
  a_cts_hold: assert property (tx_st_q == TX_IDLE && !fc_dis && !fc_func && i_flow_control_pin |=> tx_st_q == TX_IDLE) else $error("sent while not clear");
  a_err_sum: assert property (err_ev |=> ##[0:1] stat[6]) else $error("error sum not set");
  c_tx_frame: cover property (tx_done);
  c_rx_frame: cover property (rx_accept && !rx_fer_now && !rx_per_q);
  c_sleep_drop: cover property (rx_done && sleep_en && !rx_msb);
  c_collision: cover property (coll_ev);
endmodule : uao_core

/* test/uao_peer.sv */
// Far-side serial peer: sends and captures frames at a fixed number of clocks per bit
`timescale 1ns/1ps
module uao_peer #(
  parameter int BIT_CLKS = 16
) (
  input wire logic i_ref_clk,
  input wire logic i_line,
  output logic o_line
);
  initial o_line = 1'b1;
  // Parks the line at a level, so a reversed link is not mistaken for a start
  task automatic idle(input logic lvl);
    @(posedge i_ref_clk) o_line <= lvl;
  endtask : idle
  // Idle bit, start bit, then frame bits LSB first; rev flips every level
  task automatic send(input logic [12:0] f, input int len, input logic rev);
    for (int k = -2; k < len; k++) begin
      repeat (BIT_CLKS) @(posedge i_ref_clk) o_line <= rev ^ ((k == -2) ? 1'b1 : ((k == -1) ? 1'b0 : f[k]));
    end
    @(posedge i_ref_clk) o_line <= ~rev;
  endtask : send
  // Waits for a start level, samples mid-bit; a frame that never comes returns unknowns
  task automatic recv(input int len, input logic rev, output logic [12:0] f);
    int n;
    n = 0;
    f = 'x;
    while ((i_line ^ rev) !== 1'b0 && n < 20000) begin
      @(posedge i_ref_clk);
      n++;
    end
    if (n < 20000) begin
      repeat (BIT_CLKS / 2) @(posedge i_ref_clk);
      for (int k = 0; k < len; k++) begin
        repeat (BIT_CLKS) @(posedge i_ref_clk);
        f[k] = i_line ^ rev;
      end
    end
  endtask : recv
endmodule : uao_peer

/* test/tb_top.sv */
// Self-checking bench: register tasks, pin checks and serial frames against the peer
`timescale 1ns/1ps
`include "uao_defs.svh"
module tb_top;
  logic clk, rst_n, cyc, stb, we, tgt, loop, cts;
  logic [4:0] adr;
  logic [31:0] wdat, rd_a, rd_s, rdat;
  logic ack_a, ack_s, ack, out_a, oe_a, cp_a, cp_s, fo_a, foe_a, fp_a, sp_a, irq_a, line, p_line, ser_in;
  logic [12:0] f;
  logic xclk, so_s, sp_s, irq_s;
  logic [3:0] sel, lanes;
  logic [7:0] md[6] = '{8'h00, 8'h01, 8'h02, 8'h41, 8'h61, 8'h72};
  logic [7:0] fc[3] = '{8'h12, 8'h02, 8'h0A};
  logic [1:0] fx[3] = '{2'b10, 2'b00, 2'b01};
  int mismatches, check_count;
  // Released or open-drain output floats to the pull-up level
  assign line = oe_a ? out_a : 1'b1;
  assign ser_in = loop ? line : p_line;
  assign ack = tgt ? ack_s : ack_a;
  assign rdat = tgt ? rd_s : rd_a;
  uao_core #(.CHANNEL(2)) dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc & ~tgt), .i_wb_stb(stb & ~tgt),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rd_a), .o_wb_ack(ack_a),
    .i_serial_in_pin(ser_in), .o_serial_out_pin(out_a), .o_serial_out_oe(oe_a), .i_transfer_clock_pin(xclk),
    .o_transfer_clock_is_port(cp_a), .i_flow_control_pin(foe_a ? fo_a : cts), .o_flow_control_pin(fo_a),
    .o_flow_control_oe(foe_a), .o_flow_control_is_port(fp_a), .o_serial_in_is_port(sp_a), .o_irq(irq_a));
  // Sleep-capable channel shares the bus and the peer's line
  uao_core #(.CHANNEL(0)) dut_s (.i_ref_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc & tgt), .i_wb_stb(stb & tgt),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rd_s), .o_wb_ack(ack_s),
    .i_serial_in_pin(p_line), .o_serial_out_pin(so_s), .o_serial_out_oe(), .i_transfer_clock_pin(xclk),
    .o_transfer_clock_is_port(cp_s), .i_flow_control_pin(cts), .o_flow_control_pin(), .o_flow_control_oe(),
    .o_flow_control_is_port(), .o_serial_in_is_port(sp_s), .o_irq(irq_s));
  uao_peer u_peer (.i_ref_clk(clk), .i_line(line), .o_line(p_line));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // --------
  // Tasks
  // --------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic test_done();
    $display("Checks %0d, mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done
  // Classic single cycle; the request holds until ack is sampled, so no latency is assumed
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= lanes;
    adr <= a;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 64);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) begin
      mismatches++;
      test_done();
    end
  endtask : wb
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask : wr
  task automatic rchk(input logic [4:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    check(q & m, exp);
  endtask : rchk
  // Bounded poll; a bit that never sets ends the run as a failure
  task automatic poll(input logic [4:0] a, input logic [31:0] m);
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      wb(1'b0, a, 32'h0, q);
      n++;
    end while ((q & m) === 32'h0 && n < 200);
    if ((q & m) === 32'h0) begin
      mismatches++;
      test_done();
    end
  endtask : poll
  // Peer capture; a frame that never starts leaves unknowns and ends the run
  task automatic grab(input int len, input logic rev);
    u_peer.recv(len, rev, f);
    if (f[0] === 1'bx) begin
      mismatches++;
      test_done();
    end
  endtask : grab
  function automatic logic [12:0] frm(input logic [8:0] d, input int n, input logic pen, input logic ev);
    logic [12:0] r;
    logic [8:0] m;
    m = 9'h1FF >> (9 - n);
    r = 13'h1FFF;
    for (int k = 0; k < n; k++) r[k] = d[k];
    if (pen) r[n] = ev ? ^(d & m) : ~^(d & m);
    return r;
  endfunction : frm
  // One frame each way; parity follows the line data, so inversion must not touch it
  task automatic trip(input logic [7:0] mode, input logic [8:0] d, input logic inv, input logic rev);
    int n;
    int len;
    logic [8:0] m;
    logic [12:0] fm;
    n = (mode[1:0] == 2'd0) ? 7 : ((mode[1:0] == 2'd1) ? 8 : 9);
    len = n + int'(mode[6]) + int'(mode[4]) + 1;
    m = 9'h1FF >> (9 - n);
    fm = 13'h1FFF >> (13 - len);
    wr(`UAO_OFF_MODE, {24'h0, mode});
    wr(`UAO_OFF_TXBUF, {23'h0, d});
    grab(len, rev);
    check({19'h0, f & fm}, {19'h0, frm(inv ? ~d : d, n, mode[6], mode[5]) & fm});
    u_peer.send(frm(~d, n, mode[6], mode[5]), len, rev);
    poll(`UAO_OFF_STAT, 32'h04);
    rchk(`UAO_OFF_STAT, 32'h78, 32'h0);
    rchk(`UAO_OFF_RXBUF, {23'h0, m}, {23'h0, (inv ? d : ~d) & m});
  endtask : trip
  // --------
  // Tests
  // --------
  initial begin
    {cyc, stb, we, tgt, loop, rst_n} = 6'h0;
    cts = 1'b1;
    xclk = 1'b0;
    sel = 4'hF;
    lanes = 4'hF;
    adr = 5'h0;
    wdat = 32'h0;
    mismatches = 0;
    check_count = 0;
    repeat (8) @(posedge clk);
    check({out_a, oe_a, cp_a, fp_a, sp_a, irq_a, foe_a, ack_a}, 8'hB8);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rchk(`UAO_OFF_MODE, 32'hFF, 32'h01);
    rchk(`UAO_OFF_CTRL, 32'hFF, 32'h10);
    rchk(`UAO_OFF_BRG, 32'hFF, 32'h00);
    // A write without the low byte lane must be acked and ignored
    lanes = 4'hE;
    wr(`UAO_OFF_BRG, 32'h55);
    lanes = 4'hF;
    rchk(`UAO_OFF_BRG, 32'hFF, 32'h00);
    $display("Test reset done");
    // External clock asked of channel two must not take the clock pin
    wr(`UAO_OFF_MODE, 32'h09);
    wr(`UAO_OFF_CTRL, 32'h02);
    repeat (2) @(posedge clk);
    check({oe_a, line}, 2'b11);
    check(cp_a, 1'b1);
    check(sp_a, 1'b1);
    wr(`UAO_OFF_CTRL, 32'h82);
    repeat (2) @(posedge clk);
    check(oe_a, 1'b0);
    for (int i = 0; i < 3; i++) begin
      wr(`UAO_OFF_CTRL, {24'h0, fc[i]});
      repeat (2) @(posedge clk);
      check({fp_a, foe_a}, fx[i]);
    end
    check(fo_a, 1'b1);
    wr(`UAO_OFF_CTRL, 32'h06);
    repeat (2) @(posedge clk);
    check(sp_a, 1'b0);
    check(fo_a, 1'b0);
    $display("Test pins done");
    wr(`UAO_OFF_CTRL, 32'h17);
    foreach (md[i]) trip(md[i], 9'h1A5, 1'b0, 1'b0);
    wr(`UAO_OFF_CTRL, 32'h57);
    trip(8'h61, 9'h00F, 1'b1, 1'b0);
    $display("Test formats done");
    wr(`UAO_OFF_CTRL, 32'h17);
    u_peer.send(frm(9'h33, 8, 1'b1, 1'b1) ^ 13'h100, 10, 1'b0);
    poll(`UAO_OFF_STAT, 32'h04);
    rchk(`UAO_OFF_STAT, 32'h78, 32'h60);
    rchk(`UAO_OFF_RXBUF, 32'h1FF, 32'h33);
    u_peer.send(frm(9'h33, 8, 1'b1, 1'b1) ^ 13'h200, 10, 1'b0);
    poll(`UAO_OFF_STAT, 32'h04);
    rchk(`UAO_OFF_STAT, 32'h78, 32'h50);
    rchk(`UAO_OFF_RXBUF, 32'h1FF, 32'h33);
    u_peer.send(frm(9'h33, 8, 1'b1, 1'b1), 10, 1'b0);
    u_peer.send(frm(9'h44, 8, 1'b1, 1'b1), 10, 1'b0);
    poll(`UAO_OFF_STAT, 32'h04);
    rchk(`UAO_OFF_STAT, 32'h78, 32'h48);
    rchk(`UAO_OFF_RXBUF, 32'h1FF, 32'h44);
    $display("Test errors done");
    wr(`UAO_OFF_CTRL, 32'h13);
    wr(`UAO_OFF_MODE, 32'h01);
    wr(`UAO_OFF_MASK, 32'h00);
    wr(`UAO_OFF_IRQ, 32'h0F);
    loop <= 1'b1;
    wr(`UAO_OFF_TXBUF, 32'h55);
    poll(`UAO_OFF_IRQ, 32'h01);
    rchk(`UAO_OFF_IRQ, 32'h08, 32'h0);
    loop <= 1'b0;
    wr(`UAO_OFF_IRQ, 32'h0F);
    wr(`UAO_OFF_TXBUF, 32'h00);
    poll(`UAO_OFF_IRQ, 32'h01);
    rchk(`UAO_OFF_IRQ, 32'h08, 32'h08);
    check(irq_a, 1'b0);
    wr(`UAO_OFF_MASK, 32'h08);
    repeat (2) @(posedge clk);
    check(irq_a, 1'b1);
    wr(`UAO_OFF_IRQ, 32'h08);
    repeat (2) @(posedge clk);
    check(irq_a, 1'b0);
    $display("Test collision done");
    wr(`UAO_OFF_CTRL, 32'h03);
    wr(`UAO_OFF_TXBUF, 32'h3C);
    repeat (64) @(posedge clk);
    check(line, 1'b1);
    rchk(`UAO_OFF_STAT, 32'h01, 32'h01);
    cts <= 1'b0;
    grab(9, 1'b0);
    check({23'h0, f[8:0]}, {23'h0, frm(9'h03C, 8, 1'b0, 1'b0) & 13'h1FF});
    $display("Test flow done");
    tgt <= 1'b1;
    wr(`UAO_OFF_MODE, 32'h89);
    repeat (2) @(posedge clk);
    check(cp_s, 1'b0);
    // Start bit must hold until sixteen clock pin edges have passed
    wr(`UAO_OFF_CTRL, 32'h13);
    wr(`UAO_OFF_TXBUF, 32'h01);
    repeat (8) @(posedge clk);
    check(so_s, 1'b0);
    for (int i = 0; i < 16; i++) begin
      xclk <= 1'b1;
      @(posedge clk);
      xclk <= 1'b0;
      @(posedge clk);
    end
    repeat (4) @(posedge clk);
    check(so_s, 1'b1);
    wr(`UAO_OFF_MODE, 32'h81);
    wr(`UAO_OFF_MASK, 32'h06);
    wr(`UAO_OFF_CTRL, 32'h16);
    repeat (2) @(posedge clk);
    check(sp_s, 1'b0);
    // The frame has ended when send returns, so no poll is needed
    u_peer.send(frm(9'h012, 8, 1'b0, 1'b0), 9, 1'b0);
    repeat (4) @(posedge clk);
    rchk(`UAO_OFF_STAT, 32'h7C, 32'h0);
    rchk(`UAO_OFF_IRQ, 32'h06, 32'h0);
    check(irq_s, 1'b0);
    u_peer.send(frm(9'h092, 8, 1'b0, 1'b0), 9, 1'b0);
    poll(`UAO_OFF_STAT, 32'h04);
    rchk(`UAO_OFF_RXBUF, 32'hFF, 32'h92);
    check(irq_s, 1'b1);
    tgt <= 1'b0;
    $display("Test sleep done");
    wr(`UAO_OFF_CTRL, 32'h33);
    u_peer.idle(1'b0);
    wr(`UAO_OFF_CTRL, 32'h37);
    trip(8'h41, 9'h0C5, 1'b0, 1'b1);
    $display("Test reversal done");
    test_done();
  end
endmodule : tb_top
